/* hdl/dio_channel_cond.sv */
// digital i/o channel conditioning: input filter and extension, short and open
// detection with recovery, output actions on fieldbus fault or idle, ahb-lite registers
// assumes one clock, synchronous sense inputs and a single ahb-lite master
//
// Contract
// - supply short raises error only when enabled
// - inrush filter masks overcurrent 100 ms after power-up
// - ignore input changes shorter than filter time
// - hold detected input state for extension time
// - load short raises error only when enabled
// - auto recovery clears error once short gone
// - manual recovery latches error until power-up; the code also clears it when load short detection is disabled
// - per-channel open detection, disabled by default
// - comm fault: clear, hold or force output on
// - comm idle: clear, hold or force output on
// - channel actions only under software priority setting
`timescale 1ns/10ps

module dio_channel_cond
  import dio_pkg::*;
#(
  parameter int NUM_IN = 8,
  parameter int NUM_OUT = 8,
  parameter int unsigned FILT_CYC_0 = FILT_CYC0,
  parameter int unsigned FILT_CYC_1 = FILT_CYC1,
  parameter int unsigned FILT_CYC_2 = FILT_CYC2,
  parameter int unsigned FILT_CYC_3 = FILT_CYC3,
  parameter int unsigned EXT_CYC_0 = EXT_CYC0,
  parameter int unsigned EXT_CYC_1 = EXT_CYC1,
  parameter int unsigned EXT_CYC_2 = EXT_CYC2,
  parameter int unsigned EXT_CYC_3 = EXT_CYC3,
  parameter int unsigned INRUSH_CYCLES = INRUSH_CYC
) (
  input wire logic clock,
  input wire logic rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // field side
  input wire logic [NUM_IN-1:0] fieldIn,
  input wire logic supplyShort,
  input wire logic [NUM_OUT-1:0] loadShort,
  input wire logic [NUM_OUT-1:0] openLoad,
  output logic [NUM_OUT-1:0] fieldOut,
  // fieldbus side
  input wire logic [NUM_OUT-1:0] processData,
  input wire logic commFault,
  input wire logic commIdle,
  output logic [NUM_IN-1:0] inState,
  output logic irq
);

  // whole state of the block
  typedef struct packed {
    // bus data phase
    logic hreadyOut;
    logic resp;
    logic [31:0] rdata;
    logic dpWrite;
    logic [7:0] dpAddr;

    // configuration registers
    logic [CTRL_W-1:0] ctrl;
    logic [NUM_OUT-1:0] openEn;
    logic [2*NUM_OUT-1:0] faultAct;
    logic [2*NUM_OUT-1:0] idleAct;

    // input conditioning per channel
    logic [NUM_IN-1:0] fltStable;
    logic [NUM_IN-1:0][31:0] fltCnt;
    logic [NUM_IN-1:0] inHeld;
    logic [NUM_IN-1:0][31:0] extCnt;

    // power-up window
    logic [31:0] inrushCnt;
    logic inrushDone;

    // diagnostics
    logic supplyErr;
    logic [NUM_OUT-1:0] shortErr;
    logic [NUM_OUT-1:0] openErr;

    // field outputs and link history
    logic [NUM_OUT-1:0] outVal;
    logic commFaultPrev;
    logic commIdlePrev;

    // interrupts
    logic [IRQ_W-1:0] irqStat;
    logic [IRQ_W-1:0] irqMask;
    logic irq;
  } dio_state_t;

  dio_state_t st_reg;
  dio_state_t st_next;

  // resolve one channel action against the channel's current output value
  function automatic logic apply_act(input logic [1:0] act, input logic cur);
    logic res;
    res = 1'b0;
    case (act)
      DIO_ACT_CLEAR: res = 1'b0;
      DIO_ACT_HOLD: res = cur;
      DIO_ACT_DRIVE_HIGH_OVERRIDE: res = 1'b1;
      default: res = 1'b0;
    endcase
    return res;
  endfunction

  // read mux over the current state
  function automatic logic [31:0] read_reg(input dio_state_t s, input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      ADDR_CTRL: v = 32'(s.ctrl);
      ADDR_OPEN_EN: v = 32'(s.openEn);
      ADDR_FAULT_ACT: v = 32'(s.faultAct);
      ADDR_IDLE_ACT: v = 32'(s.idleAct);
      ADDR_SUPPLY_ERR: v = 32'(s.supplyErr);
      ADDR_SHORT_ERR: v = 32'(s.shortErr);
      ADDR_OPEN_ERR: v = 32'(s.openErr);
      ADDR_IN_STATE: v = 32'(s.inHeld);
      ADDR_IRQ_STAT: v = 32'(s.irqStat);
      ADDR_IRQ_MASK: v = 32'(s.irqMask);
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  // next-state logic for bus, conditioning, diagnostics and outputs
  always_comb begin
    logic [31:0] filtLim;
    logic [31:0] extLim;
    logic [IRQ_W-1:0] irqClr;
    logic [IRQ_W-1:0] irqEv;
    logic detActive;
    logic loadEn;
    logic manual;
    logic [1:0] act;

    // scratch values set to defaults on every pass (filter and extension lengths to one, the rest to zero)
    filtLim = 32'h0000_0001;
    extLim = 32'h0000_0001;
    irqClr = '0;
    irqEv = '0;
    detActive = 1'b0;
    loadEn = 1'b0;
    manual = 1'b0;
    act = 2'b00;

    // every field keeps its value unless set below
    st_next = st_reg;

    // zero-wait slave: always ready, always okay
    st_next.hreadyOut = 1'b1;
    st_next.resp = 1'b0;

    // data phase of a write lands here
    if (st_reg.dpWrite) begin
      case (st_reg.dpAddr)
        ADDR_CTRL: st_next.ctrl = hwdata[CTRL_W-1:0];
        ADDR_OPEN_EN: st_next.openEn = hwdata[NUM_OUT-1:0];
        ADDR_FAULT_ACT: st_next.faultAct = hwdata[2*NUM_OUT-1:0];
        ADDR_IDLE_ACT: st_next.idleAct = hwdata[2*NUM_OUT-1:0];
        ADDR_IRQ_STAT: irqClr = hwdata[IRQ_W-1:0];
        ADDR_IRQ_MASK: st_next.irqMask = hwdata[IRQ_W-1:0];
        default: irqClr = '0; // unmapped or read-only: ignored
      endcase
    end

    // address phase: capture the transfer, read data stands in the data phase
    if (hsel && hready && htrans[1]) begin
      st_next.dpWrite = hwrite;
      st_next.dpAddr = haddr[7:0];
      st_next.rdata = hwrite ? 32'h0000_0000 : read_reg(st_reg, haddr[7:0]);
    end else begin
      st_next.dpWrite = 1'b0;
    end

    // select filter and extension lengths
    case (st_reg.ctrl[CTRL_FILT_LSB +: 2])
      2'b00: filtLim = 32'(FILT_CYC_0);
      2'b01: filtLim = 32'(FILT_CYC_1);
      2'b10: filtLim = 32'(FILT_CYC_2);
      2'b11: filtLim = 32'(FILT_CYC_3);
      default: filtLim = 32'(FILT_CYC_1);
    endcase
    case (st_reg.ctrl[CTRL_EXT_LSB +: 2])
      2'b00: extLim = 32'(EXT_CYC_0);
      2'b01: extLim = 32'(EXT_CYC_1);
      2'b10: extLim = 32'(EXT_CYC_2);
      2'b11: extLim = 32'(EXT_CYC_3);
      default: extLim = 32'(EXT_CYC_1);
    endcase

    // input glitch filter and pulse extension per channel
    for (int i = 0; i < NUM_IN; i++) begin
      // a change must persist for the filter length
      if (fieldIn[i] == st_reg.fltStable[i]) begin
        st_next.fltCnt[i] = 32'h0000_0000;
      end else if (st_reg.fltCnt[i] >= filtLim - 32'h0000_0001) begin
        st_next.fltStable[i] = fieldIn[i];
        st_next.fltCnt[i] = 32'h0000_0000;
      end else begin
        st_next.fltCnt[i] = st_reg.fltCnt[i] + 32'h0000_0001;
      end
      // a new state is held for the extension length
      if (st_reg.extCnt[i] != 32'h0000_0000) begin
        st_next.extCnt[i] = st_reg.extCnt[i] - 32'h0000_0001;
      end else if (st_reg.inHeld[i] != st_reg.fltStable[i]) begin
        st_next.inHeld[i] = st_reg.fltStable[i];
        st_next.extCnt[i] = extLim - 32'h0000_0001;
      end
    end

    // inrush window counted from power-up (reset release)
    if (!st_reg.inrushDone) begin
      st_next.inrushCnt = st_reg.inrushCnt + 32'h0000_0001;
      if (st_reg.inrushCnt >= 32'(INRUSH_CYCLES) - 32'h0000_0001) begin
        st_next.inrushDone = 1'b1;
      end
    end

    // overcurrent detection gate
    detActive = !st_reg.ctrl[CTRL_INRUSH_EN] || st_reg.inrushDone;

    // supply short error follows the sense line while enabled
    st_next.supplyErr = st_reg.ctrl[CTRL_SUPPLY_EN] & supplyShort;

    // load short per channel, with auto or latched recovery
    loadEn = st_reg.ctrl[CTRL_LOAD_EN];
    manual = st_reg.ctrl[CTRL_MANUAL];
    for (int i = 0; i < NUM_OUT; i++) begin
      st_next.shortErr[i] = loadEn & ((loadShort[i] & detActive) |
                                      (manual & st_reg.shortErr[i]));
    end

    // open load error per channel, only where enabled
    for (int i = 0; i < NUM_OUT; i++) begin
      st_next.openErr[i] = st_reg.openEn[i] & openLoad[i];
    end

    // field outputs: received data, or the fault/idle action
    for (int i = 0; i < NUM_OUT; i++) begin
      // fault outranks idle
      if (commFault) begin
        if (st_reg.ctrl[CTRL_SW_PRIO]) begin
          act = st_reg.faultAct[2*i +: 2];
        end else begin
          act = st_reg.ctrl[CTRL_SYS_HOLD] ? DIO_ACT_HOLD : DIO_ACT_CLEAR;
        end
        st_next.outVal[i] = apply_act(act, st_reg.outVal[i]);
      end else if (commIdle) begin
        if (st_reg.ctrl[CTRL_SW_PRIO]) begin
          act = st_reg.idleAct[2*i +: 2];
        end else begin
          act = st_reg.ctrl[CTRL_SYS_HOLD] ? DIO_ACT_HOLD : DIO_ACT_CLEAR;
        end
        st_next.outVal[i] = apply_act(act, st_reg.outVal[i]);
      end else begin
        st_next.outVal[i] = processData[i];
      end
    end

    // link state history for edge detection
    st_next.commFaultPrev = commFault;
    st_next.commIdlePrev = commIdle;

    // interrupt events: rising edges of errors and link states
    irqEv[IRQ_SUPPLY] = st_next.supplyErr & ~st_reg.supplyErr;
    irqEv[IRQ_SHORT] = |(st_next.shortErr & ~st_reg.shortErr);
    irqEv[IRQ_OPEN] = |(st_next.openErr & ~st_reg.openErr);
    irqEv[IRQ_COMM_FAULT] = commFault & ~st_reg.commFaultPrev;
    irqEv[IRQ_COMM_IDLE] = commIdle & ~st_reg.commIdlePrev;

    // sticky status, a new event wins over a write-one clear
    st_next.irqStat = (st_reg.irqStat & ~irqClr) | irqEv;
    st_next.irq = |(st_next.irqStat & st_next.irqMask);
  end

  // state register, synchronous reset stands for power-up
  always_ff @(posedge clock) begin
    if (rst) begin
      // bus side
      st_reg.hreadyOut <= 1'b1;
      st_reg.resp <= 1'b0;
      st_reg.rdata <= 32'h0000_0000;
      st_reg.dpWrite <= 1'b0;
      st_reg.dpAddr <= 8'h00;

      // configuration
      st_reg.ctrl <= CTRL_RESET;
      st_reg.openEn <= '0;
      st_reg.faultAct <= '0;
      st_reg.idleAct <= '0;

      // input conditioning
      st_reg.fltStable <= '0;
      st_reg.fltCnt <= '0;
      st_reg.inHeld <= '0;
      st_reg.extCnt <= '0;

      // power-up window restarts
      st_reg.inrushCnt <= 32'h0000_0000;
      st_reg.inrushDone <= 1'b0;

      // diagnostics, latched shorts included
      st_reg.supplyErr <= 1'b0;
      st_reg.shortErr <= '0;
      st_reg.openErr <= '0;

      // field outputs and link history
      st_reg.outVal <= '0;
      st_reg.commFaultPrev <= 1'b0;
      st_reg.commIdlePrev <= 1'b0;

      // interrupts
      st_reg.irqStat <= '0;
      st_reg.irqMask <= IRQ_MASK_RESET;
      st_reg.irq <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state register
  assign hreadyout = st_reg.hreadyOut;
  assign hrdata = st_reg.rdata;
  assign hresp = st_reg.resp;
  assign fieldOut = st_reg.outVal;
  assign inState = st_reg.inHeld;
  assign irq = st_reg.irq;

endmodule

/* include/dio_pkg.sv */
// constants, register map and enumerations of the digital i/o conditioning block
// assumes a 250 MHz system clock; times are kept in microseconds
package dio_pkg;

  // clock rate and the times that the conditioning stages use
  localparam int CLK_MHZ = 250;
  localparam int FILT_T0_US = 100;
  localparam int FILT_T1_US = 1000;
  localparam int FILT_T2_US = 10000;
  localparam int FILT_T3_US = 20000;
  localparam int EXT_T0_US = 1000;
  localparam int EXT_T1_US = 15000;
  localparam int EXT_T2_US = 100000;
  localparam int EXT_T3_US = 200000;
  localparam int INRUSH_T_US = 100000;

  // the same times as clock cycles
  localparam int FILT_CYC0 = FILT_T0_US * CLK_MHZ;
  localparam int FILT_CYC1 = FILT_T1_US * CLK_MHZ;
  localparam int FILT_CYC2 = FILT_T2_US * CLK_MHZ;
  localparam int FILT_CYC3 = FILT_T3_US * CLK_MHZ;
  localparam int EXT_CYC0 = EXT_T0_US * CLK_MHZ;
  localparam int EXT_CYC1 = EXT_T1_US * CLK_MHZ;
  localparam int EXT_CYC2 = EXT_T2_US * CLK_MHZ;
  localparam int EXT_CYC3 = EXT_T3_US * CLK_MHZ;
  localparam int INRUSH_CYC = INRUSH_T_US * CLK_MHZ;

  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_OPEN_EN = 8'h04;
  localparam logic [7:0] ADDR_FAULT_ACT = 8'h08;
  localparam logic [7:0] ADDR_IDLE_ACT = 8'h0C;
  localparam logic [7:0] ADDR_SUPPLY_ERR = 8'h10;
  localparam logic [7:0] ADDR_SHORT_ERR = 8'h14;
  localparam logic [7:0] ADDR_OPEN_ERR = 8'h18;
  localparam logic [7:0] ADDR_IN_STATE = 8'h1C;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h20;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h24;

  // control register fields
  localparam int CTRL_W = 10;
  localparam int CTRL_SUPPLY_EN = 0;
  localparam int CTRL_INRUSH_EN = 1;
  localparam int CTRL_FILT_LSB = 2;
  localparam int CTRL_EXT_LSB = 4;
  localparam int CTRL_LOAD_EN = 6;
  localparam int CTRL_MANUAL = 7;
  localparam int CTRL_SW_PRIO = 8;
  localparam int CTRL_SYS_HOLD = 9;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 10'h155;

  // interrupt status and mask fields
  localparam int IRQ_W = 5;
  localparam int IRQ_SUPPLY = 0;
  localparam int IRQ_SHORT = 1;
  localparam int IRQ_OPEN = 2;
  localparam int IRQ_COMM_FAULT = 3;
  localparam int IRQ_COMM_IDLE = 4;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 5'h00;

  // per-channel output action on fault or idle
  typedef enum logic [1:0] {
    DIO_ACT_CLEAR,
    DIO_ACT_HOLD,
    DIO_ACT_DRIVE_HIGH_OVERRIDE
  } dio_act_t;

endpackage

/* verification/dio_cond_asserts.sv */
// checker for the conditioning block, bound to its top module
// assumes one ahb-lite master; per-channel output actions are checked on channel 0, system actions and pass-through on all channels
`timescale 1ns/10ps
module dio_cond_asserts
  import dio_pkg::*;
#(
  parameter int NUM_IN = 8,
  parameter int NUM_OUT = 8
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic [NUM_IN-1:0] fieldIn,
  input wire logic [NUM_IN-1:0] inState,
  input wire logic [NUM_OUT-1:0] processData,
  input wire logic commFault,
  input wire logic commIdle,
  input wire logic [NUM_OUT-1:0] fieldOut
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic wrPend_reg;
  logic [7:0] wrAddr_reg;
  logic [9:0] ctrl_reg;
  logic [1:0] fault_reg;
  logic [1:0] idle_reg;
  // shadow of the config words written over the bus
  always_ff @(posedge clock) begin
    wrPend_reg <= !rst && hsel && hready && htrans[1] && hwrite;
    wrAddr_reg <= haddr[7:0];
    if (rst) begin
      ctrl_reg <= CTRL_RESET;
      fault_reg <= 2'h0;
      idle_reg <= 2'h0;
    end else if (wrPend_reg) begin
      if (wrAddr_reg == ADDR_CTRL) ctrl_reg <= hwdata[9:0];
      if (wrAddr_reg == ADDR_FAULT_ACT) fault_reg <= hwdata[1:0];
      if (wrAddr_reg == ADDR_IDLE_ACT) idle_reg <= hwdata[1:0];
    end
  end
  property p_pass;
    $past(!commFault && !commIdle && !rst) |-> fieldOut == $past(processData);
  endproperty
  a_pass: assert property (p_pass) else $error("output not following data");
  property p_fault;
    $past(commFault && ctrl_reg[CTRL_SW_PRIO] && !rst) |-> fieldOut[0] ==
      ($past(fault_reg) == 2'h2 || ($past(fault_reg) == 2'h1 && $past(fieldOut[0])));
  endproperty
  a_fault: assert property (p_fault) else $error("bad fault action");
  property p_idle;
    $past(commIdle && !commFault && ctrl_reg[CTRL_SW_PRIO] && !rst) |-> fieldOut[0] ==
      ($past(idle_reg) == 2'h2 || ($past(idle_reg) == 2'h1 && $past(fieldOut[0])));
  endproperty
  a_idle: assert property (p_idle) else $error("bad idle action");
  property p_sys;
    $past((commFault || commIdle) && !ctrl_reg[CTRL_SW_PRIO] && !rst) |->
      fieldOut == ($past(ctrl_reg[CTRL_SYS_HOLD]) ? $past(fieldOut) : '0);
  endproperty
  a_sys: assert property (p_sys) else $error("bad system action");
  property p_filt;
    $changed(inState) && !$past(rst) |->
      ((inState ^ $past(inState)) & (inState ^ $past(fieldIn, 3))) == '0;
  endproperty
  a_filt: assert property (p_filt) else $error("input change not settled");
  property p_ext;
    $rose(inState[0]) |=> $stable(inState[0]) [*3];
  endproperty
  a_ext: assert property (p_ext) else $error("input not held");
  property p_unmap;
    hsel && hready && htrans[1] && !hwrite && haddr[7:0] > ADDR_IRQ_MASK |=> hrdata == '0;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_bus;
    hreadyout && !hresp;
  endproperty
  a_bus: assert property (p_bus) else $error("bus stalled or errored");
endmodule
bind dio_channel_cond dio_cond_asserts #(.NUM_IN(NUM_IN), .NUM_OUT(NUM_OUT)) u_chk (.*);

/* verification/dio_host_model.sv */
// fieldbus host stand-in: process data plus fault and idle flags
// assumes the bench selects the link state through mode
`timescale 1ns/10ps
module dio_host_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic [1:0] mode,
  input wire logic [7:0] dataIn,
  output logic [7:0] processData,
  output logic commFault,
  output logic commIdle
);
  // link state and data, one edge behind the command
  always_ff @(posedge clock) begin
    if (rst) begin
      processData <= 8'h00;
      commFault <= 1'b0;
      commIdle <= 1'b0;
    end else begin
      commFault <= (mode == 2'h1);
      commIdle <= (mode == 2'h2);
      // data is not valid while the link is down, so it keeps moving
      processData <= (mode == 2'h0) ? dataIn : ~processData;
    end
  end
endmodule

/* verification/tb_digital_io_channel_conditioning.sv */
// self-checking bench for the conditioning block with a host stand-in
// assumes shortened filter, extension and inrush counts set below
`timescale 1ns/10ps
module tb_digital_io_channel_conditioning;
  import dio_pkg::*;
  logic clock, rst, hsel, hwrite, hready, hreadyout, hresp, supplyShort, irq;
  logic commFault, commIdle;
  logic [1:0] htrans, mode;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [7:0] fieldIn, loadShort, openLoad, fieldOut, processData, inState, dataIn;
  logic [15:0] seed;
  int badCount, checksDone, i, s, m, a, n;
  localparam int FI [4] = '{3, 5, 7, 9};
  localparam int EX [4] = '{4, 6, 8, 10};
  assign hready = hreadyout;
  dio_channel_cond #(
    .FILT_CYC_0(3), .FILT_CYC_1(5), .FILT_CYC_2(7), .FILT_CYC_3(9),
    .EXT_CYC_0(4), .EXT_CYC_1(6), .EXT_CYC_2(8), .EXT_CYC_3(10), .INRUSH_CYCLES(20)
  ) u_dut (.*);
  dio_host_model u_host (.*);
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  task automatic completeRun;
    if (badCount == 0 && checksDone > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      badCount++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one edge, then a bounded wait for hready
  task automatic hwait;
    int k;
    k = 0;
    @(posedge clock);
    while (hready !== 1'b1 && k < 20) begin
      @(posedge clock);
      k++;
    end
    if (hready !== 1'b1) begin
      badCount++;
      completeRun();
    end
  endtask
  task automatic bus(input logic [7:0] ad, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, ad};
    hwrite <= w;
    htrans <= 2'h2;
    hwait();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    hwait();
    q = hrdata;
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] e);
    bus(ad, 1'b0, 32'h0);
    chk(q, e);
  endtask
  // count half-settled cycles until inState shows e
  task automatic wt(input logic [7:0] e);
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (inState !== e && n < 400);
    if (n >= 400) begin
      badCount++;
      completeRun();
    end
  endtask
  function automatic logic [7:0] act_out(int c, logic [7:0] d);
    return (c == 2) ? 8'hFF : ((c == 1) ? d : 8'h00);
  endfunction
  function automatic logic [15:0] lfsr(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  initial begin
    {rst, hsel, haddr, htrans, hwrite, hwdata, mode, dataIn} = '0;
    {fieldIn, supplyShort, loadShort, openLoad, badCount, checksDone} = '0;
    rst = 1'b1;
    hsize = 3'h2;
    seed = 16'h2F87;
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rd(ADDR_CTRL, {22'h0, CTRL_RESET});
    rd(ADDR_IRQ_MASK, 32'h0);
    rd(8'h3C, 32'h0);
    // random process data passes straight through
    for (i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      dataIn <= seed[7:0];
      repeat (3) @(posedge clock);
      chk(fieldOut, seed[7:0]);
    end
    // every action on fault and on idle, then recovery
    for (m = 1; m < 3; m++) begin
      for (a = 0; a < 3; a++) begin
        wr_both(32'h5555 * a);
        mode <= 2'(m);
        repeat (4) @(posedge clock);
        chk(fieldOut, act_out(a, dataIn));
        mode <= 2'h0;
        repeat (3) @(posedge clock);
        chk(fieldOut, dataIn);
      end
    end
    // system-level hold, then clear
    bus(ADDR_CTRL, 1'b1, 32'h255);
    mode <= 2'h1;
    repeat (4) @(posedge clock);
    chk(fieldOut, dataIn);
    bus(ADDR_CTRL, 1'b1, 32'h55);
    mode <= 2'h2;
    repeat (4) @(posedge clock);
    chk(fieldOut, 32'h0);
    mode <= 2'h0;
    // glitch rejection and hold time for every setting
    for (s = 0; s < 4; s++) begin
      bus(ADDR_CTRL, 1'b1, 32'h141 | (s << 2) | (s << 4));
      fieldIn <= 8'hFF;
      repeat (FI[s] - 1) @(posedge clock);
      fieldIn <= 8'h00;
      repeat (12) @(posedge clock);
      chk(inState, 32'h0);
      fieldIn <= 8'hFF;
      wt(8'hFF);
      chk(32'(n >= FI[s]), 32'h1);
      @(posedge clock);
      fieldIn <= 8'h00;
      wt(8'h00);
      chk(32'(n >= EX[s] - 1 && n <= FI[s] + EX[s] + 4), 32'h1);
      @(posedge clock);
    end
    // supply short with interrupt raised, cleared and disabled
    bus(ADDR_CTRL, 1'b1, 32'h155);
    bus(ADDR_IRQ_STAT, 1'b1, 32'h1F);
    bus(ADDR_IRQ_MASK, 1'b1, 32'h1F);
    chk(irq, 32'h0);
    supplyShort <= 1'b1;
    repeat (3) @(posedge clock);
    chk(irq, 32'h1);
    rd(ADDR_SUPPLY_ERR, 32'h1);
    supplyShort <= 1'b0;
    bus(ADDR_IRQ_STAT, 1'b1, 32'h1F);
    repeat (2) @(posedge clock);
    chk(irq, 32'h0);
    bus(ADDR_CTRL, 1'b1, 32'h154);
    bus(ADDR_IRQ_MASK, 1'b1, 32'h0);
    supplyShort <= 1'b1;
    repeat (3) @(posedge clock);
    rd(ADDR_SUPPLY_ERR, 32'h0);
    supplyShort <= 1'b0;
    // load short: auto recovery, manual latch, detection off
    bus(ADDR_CTRL, 1'b1, 32'h155);
    loadShort <= 8'h01;
    repeat (3) @(posedge clock);
    rd(ADDR_SHORT_ERR, 32'h1);
    chk(irq, 32'h0);
    loadShort <= 8'h00;
    repeat (3) @(posedge clock);
    rd(ADDR_SHORT_ERR, 32'h0);
    bus(ADDR_CTRL, 1'b1, 32'h1D5);
    loadShort <= 8'h02;
    repeat (3) @(posedge clock);
    loadShort <= 8'h00;
    repeat (3) @(posedge clock);
    rd(ADDR_SHORT_ERR, 32'h2);
    bus(ADDR_CTRL, 1'b1, 32'h195);
    loadShort <= 8'h04;
    repeat (3) @(posedge clock);
    rd(ADDR_SHORT_ERR, 32'h0);
    loadShort <= 8'h00;
    // open load, off by default then enabled on channel 1
    openLoad <= 8'h02;
    repeat (3) @(posedge clock);
    rd(ADDR_OPEN_ERR, 32'h0);
    bus(ADDR_OPEN_EN, 1'b1, 32'h2);
    repeat (2) @(posedge clock);
    rd(ADDR_OPEN_ERR, 32'h2);
    openLoad <= 8'h00;
    // random field inputs and sense lines against the rules
    bus(ADDR_CTRL, 1'b1, 32'h155);
    bus(ADDR_OPEN_EN, 1'b1, 32'hFF);
    seed = lfsr(seed);
    loadShort <= seed[7:0];
    openLoad <= seed[15:8];
    supplyShort <= seed[3];
    fieldIn <= seed[15:8];
    wt(seed[15:8]);
    rd(ADDR_SHORT_ERR, {24'h0, seed[7:0]});
    rd(ADDR_OPEN_ERR, {24'h0, seed[15:8]});
    rd(ADDR_SUPPLY_ERR, {31'h0, seed[3]});
    {loadShort, openLoad, supplyShort, fieldIn} <= '0;
    wt(8'h00);
    // power-up again: short masked inside the inrush window only
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    bus(ADDR_CTRL, 1'b1, 32'h157);
    loadShort <= 8'h01;
    repeat (2) @(posedge clock);
    rd(ADDR_SHORT_ERR, 32'h0);
    repeat (25) @(posedge clock);
    rd(ADDR_SHORT_ERR, 32'h1);
    completeRun();
  end
  task automatic wr_both(input logic [31:0] v);
    bus(ADDR_FAULT_ACT, 1'b1, v);
    bus(ADDR_IDLE_ACT, 1'b1, v);
  endtask
endmodule
